// >>> rtl/ssp_consts.vh
// constants of the synchronous sram port with wait time-out interrupt
// assumes one 250 mhz reference clock and an externally supplied memory link clock
//
// Operation
// - time-out when ready input stays waiting beyond the extension limit; interrupt may follow
// - writing 1 to enable-set enables, 1 to enable-clear disables; 0 has no effect
// - enable-set and enable-clear bits both read 1 when enabled, 0 when disabled
// - raw time-out flag sets on every time-out, enabled or not
// - gated time-out flag sets only when the interrupt is enabled
// - writing 1 to raw or gated flag clears both flags together
// - only chip selects five down to two serve synchronous accesses
// - address pins carry 32-bit aligned address, 64-bit aligned for 64-bit devices
// - bank pins unused for 32/64-bit; 16-bit uses upper pin; 8-bit uses both
// - byte enables used: eight for 64, four for 32, two for 16, one for 8
// - bursts issue a fresh command with new address every cycle, no burst advance
// - burst end with nothing pending for that chip select issues a deselect cycle
// - sync read drives chip select and address strobe low, new address each cycle
// - output enable asserts one cycle before programmed read latency elapses
// - read ends with deselect (cs high, strobe low); output enable released afterwards
// - read byte enables stay high unless read byte enable drive bit is set
// - sync write drives cs, strobe, write enable low with address, enables, data
// - read latency field: 10b gives two cycles, 01b gives one cycle
// - write latency field delays data: 00b none, 10b two cycles
// - read enable select 0: pin is address strobe; 1: read enable for fifo glue
// - chip select extend 1: on reads cs follows output enable
// - sync select bit 1 gives synchronous timing to that chip select
// - turnaround: count plus two around async, none same-cs reads, else one; the code also gives none between two writes
// - on extension counter expiry the access proceeds to hold regardless of ready
// - soft reset clears state machine, queues, interrupt registers; hard reset everything
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH
`define SSP_DW 64
`define SSP_BEW 8
`define SSP_AW 20
`define SSP_REQ_AW 23
`define SSP_BUF_W 72
`define SSP_BUF_DEPTH 2
`define SSP_PIPE 4
`define SSP_W8 2'b00
`define SSP_W16 2'b01
`define SSP_W32 2'b10
`define SSP_W64 2'b11
`define SSP_TA_ASYNC_EXTRA 3'h2
`define SSP_TA_DIFFER 3'h1
`define SSP_IRQ_EN_RST 1'b0
`endif

// >>> rtl/ssp_sync2.v
// two flip-flop synchroniser for signals from outside the reference clock
// assumes each bit changes independently and is held for several clocks
module ssp_sync2 #(
  parameter W = 1
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // ssp_sync2

// >>> rtl/ssp_buf2.v
// small fifo between the write data source and the memory sequencer
// assumes source and sink on the same clock; ready and flags come from flops
module ssp_buf2 #(
  parameter W = 72,
  parameter DEPTH = 2,
  parameter PW = 1
) (
  input wire clk,
  input wire clr,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_reg [0:DEPTH-1];
  reg [PW-1:0] wr_ptr_reg;
  reg [PW-1:0] rd_ptr_reg;
  reg [PW:0] count_reg;
  wire push;
  wire pop;
  wire [PW:0] count_next;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_reg[rd_ptr_reg];
  assign count_next = count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (clr) begin
      wr_ptr_reg <= {PW{1'b0}};
      rd_ptr_reg <= {PW{1'b0}};
      count_reg <= {(PW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {PW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {PW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready <= (count_next != DEPTH);
      out_valid <= (count_next != 0);
    end
  end
endmodule // ssp_buf2

// >>> rtl/ssp_top.v
// synchronous sram port sequencer with asynchronous wait time-out interrupt
// assumes link_clk is the memory clock from outside; pins settle between its edges
`include "ssp_consts.vh"
module ssp_top (
  input wire ref_clk,
  input wire rst,
  input wire soft_rst,
  input wire link_clk,
  input wire async_ready_in,
  input wire [63:0] ext_data_in,
  input wire req_valid,
  output reg req_ready,
  input wire req_write,
  input wire [1:0] req_cs,
  input wire [22:0] req_addr,
  input wire [3:0] req_len,
  input wire wr_valid,
  output wire wr_ready,
  input wire [63:0] wr_data,
  input wire [7:0] wr_be,
  output reg rd_valid,
  output reg [63:0] rd_data,
  input wire [3:0] sync_select,
  input wire [7:0] read_latency_field,
  input wire [7:0] write_latency_field,
  input wire [3:0] chip_select_extend,
  input wire [3:0] read_byte_enable_drive,
  input wire [3:0] read_enable_select,
  input wire [7:0] bus_width_select,
  input wire [1:0] turnaround_count,
  input wire [7:0] wait_extension_limit,
  input wire async_ready_wait_high,
  input wire irq_enable_set_wr,
  input wire timeout_irq_enable_set,
  input wire irq_enable_clear_wr,
  input wire timeout_irq_enable_clear,
  input wire irq_unmasked_wr,
  input wire timeout_raw_flag,
  input wire irq_gated_wr,
  input wire timeout_gated_flag,
  output reg irq_enable_set_reg,
  output reg irq_enable_clear_reg,
  output reg irq_unmasked_reg,
  output reg irq_gated_reg,
  output reg timeout_irq,
  output reg memory_clock_out,
  output reg [3:0] chip_select_n,
  output reg [19:0] ext_address_out,
  output reg [1:0] bank_out,
  output reg [7:0] byte_enable_n,
  output reg [63:0] ext_data_out,
  output reg ext_data_oe,
  output reg addr_strobe_or_read_en,
  output reg sync_output_enable_pin,
  output reg sync_write_enable_pin,
  output reg async_strobe_n
);
  localparam ST_IDLE = 3'd0;
  localparam ST_TURN = 3'd1;
  localparam ST_BURST = 3'd2;
  localparam ST_DESEL = 3'd3;
  localparam ST_DRAIN = 3'd4;
  localparam ST_ASTB = 3'd5;
  localparam ST_AHOLD = 3'd6;

  function [19:0] ssp_ea;
    input [22:0] a;
    input [1:0] w;
    ssp_ea = (w == `SSP_W64) ? a[22:3] : a[21:2];
  endfunction

  function [1:0] ssp_ba;
    input [22:0] a;
    input [1:0] w;
    case (w)
      `SSP_W8: ssp_ba = a[1:0];
      `SSP_W16: ssp_ba = {a[1], 1'b0};
      default: ssp_ba = 2'b00;
    endcase
  endfunction

  function [7:0] ssp_lanes;
    input [1:0] w;
    case (w)
      `SSP_W64: ssp_lanes = 8'hff;
      `SSP_W32: ssp_lanes = 8'h0f;
      `SSP_W16: ssp_lanes = 8'h03;
      default: ssp_lanes = 8'h01;
    endcase
  endfunction

  function [22:0] ssp_step;
    input [22:0] a;
    input [1:0] w;
    ssp_step = a + (23'h000001 << w);
  endfunction

  // latency code 00 has no meaning here, treat it as one cycle
  function [1:0] ssp_lat;
    input [1:0] f;
    ssp_lat = (f == 2'b00) ? 2'b01 : f;
  endfunction

  wire clr;
  wire link_s;
  wire [64:0] pin_s;
  wire ready_s;
  wire [63:0] data_s;
  wire tick;
  wire take;
  wire buf_valid;
  wire [71:0] buf_data;
  reg pop;
  reg link_d_reg;

  reg [2:0] state_reg, state_next;
  reg have_req_reg, have_req_next;
  reg cur_wr_reg, cur_wr_next;
  reg [1:0] cur_cs_reg, cur_cs_next;
  reg [22:0] cur_addr_reg, cur_addr_next;
  reg [3:0] beats_reg, beats_next;
  reg prev_valid_reg, prev_valid_next;
  reg prev_async_reg, prev_async_next;
  reg prev_wr_reg, prev_wr_next;
  reg [1:0] prev_cs_reg, prev_cs_next;
  reg [2:0] ta_cnt_reg, ta_cnt_next;
  reg [7:0] ext_cnt_reg, ext_cnt_next;
  reg [3:0] rd_pipe_reg, rd_pipe_next;
  reg [3:0] wv_pipe_reg, wv_pipe_next;
  reg [287:0] wd_pipe_reg, wd_pipe_next;
  reg [3:0] cs_n_next;
  reg [19:0] ea_next;
  reg [1:0] ba_next;
  reg [7:0] be_n_next;
  reg [63:0] dout_next;
  reg doe_next, ads_next, soe_next, swe_next, astb_next;
  reg rd_valid_next;
  reg [63:0] rd_data_next;
  reg timeout, issue, enter, async_drive, cont, soe_on;
  reg [2:0] ta_calc;
  reg irq_en_next, raw_next, gated_next;

  // per chip select configuration of the access in hand and of reads and writes in flight
  wire cur_async = ~sync_select[cur_cs_reg];
  wire [1:0] cur_w = bus_width_select[{cur_cs_reg, 1'b0} +: 2];
  wire [7:0] lanes = ssp_lanes(cur_w);
  wire cur_ext = chip_select_extend[cur_cs_reg];
  wire cur_sre = read_enable_select[cur_cs_reg];
  wire cur_rbe = read_byte_enable_drive[cur_cs_reg];
  wire [1:0] rl_p = ssp_lat(read_latency_field[{prev_cs_reg, 1'b0} +: 2]);
  wire [1:0] wl_p = write_latency_field[{prev_cs_reg, 1'b0} +: 2];
  wire wait_now = (ready_s == async_ready_wait_high);

  assign clr = rst | soft_rst;
  assign ready_s = pin_s[64];
  assign data_s = pin_s[63:0];
  assign tick = link_s & ~link_d_reg;
  assign take = req_valid & req_ready;

  ssp_sync2 #(.W(1)) u_link_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(link_clk),
    .q(link_s)
  );

  ssp_sync2 #(.W(65)) u_pin_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({async_ready_in, ext_data_in}),
    .q(pin_s)
  );

  // back-pressure reaches the writer through wr_ready
  ssp_buf2 #(.W(`SSP_BUF_W), .DEPTH(`SSP_BUF_DEPTH), .PW(1)) u_wbuf (
    .clk(ref_clk),
    .clr(clr),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_be, wr_data}),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_data)
  );

  always @* begin
    if (!prev_valid_reg) begin
      ta_calc = 3'h0;
    end else if (prev_async_reg | cur_async) begin
      ta_calc = {1'b0, turnaround_count} + `SSP_TA_ASYNC_EXTRA;
    end else if (!prev_wr_reg && !cur_wr_reg) begin
      ta_calc = (prev_cs_reg == cur_cs_reg) ? 3'h0 : `SSP_TA_DIFFER;
    end else if (prev_wr_reg && cur_wr_reg) begin
      ta_calc = 3'h0;
    end else begin
      ta_calc = `SSP_TA_DIFFER;
    end
  end

  always @* begin
    state_next = state_reg;
    have_req_next = have_req_reg;
    cur_wr_next = cur_wr_reg;
    cur_cs_next = cur_cs_reg;
    cur_addr_next = cur_addr_reg;
    beats_next = beats_reg;
    prev_valid_next = prev_valid_reg;
    prev_async_next = prev_async_reg;
    prev_wr_next = prev_wr_reg;
    prev_cs_next = prev_cs_reg;
    ta_cnt_next = ta_cnt_reg;
    ext_cnt_next = ext_cnt_reg;
    rd_pipe_next = rd_pipe_reg;
    wv_pipe_next = wv_pipe_reg;
    wd_pipe_next = wd_pipe_reg;
    cs_n_next = chip_select_n;
    ea_next = ext_address_out;
    ba_next = bank_out;
    be_n_next = byte_enable_n;
    dout_next = ext_data_out;
    doe_next = ext_data_oe;
    ads_next = addr_strobe_or_read_en;
    soe_next = sync_output_enable_pin;
    swe_next = sync_write_enable_pin;
    astb_next = async_strobe_n;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data;
    timeout = 1'b0;
    pop = 1'b0;
    issue = 1'b0;
    enter = 1'b0;
    async_drive = 1'b0;
    soe_on = 1'b0;
    cont = have_req_reg & ~cur_async & prev_valid_reg & ~prev_async_reg &
           (cur_cs_reg == prev_cs_reg) & (cur_wr_reg == prev_wr_reg);
    if (take) begin
      have_req_next = 1'b1;
      cur_wr_next = req_write;
      cur_cs_next = req_cs;
      cur_addr_next = req_addr;
      beats_next = req_len;
    end
    // outputs move only on link edges; idle levels unless a state drives them
    if (tick) begin
      cs_n_next = 4'hf;
      ads_next = 1'b1;
      swe_next = 1'b1;
      be_n_next = 8'hff;
      astb_next = 1'b1;
      rd_pipe_next = {rd_pipe_reg[2:0], 1'b0};
      wv_pipe_next = {wv_pipe_reg[2:0], 1'b0};
      wd_pipe_next = {wd_pipe_reg[215:0], buf_data};
      if (rd_pipe_reg[rl_p]) begin
        rd_valid_next = 1'b1;
        rd_data_next = data_s;
      end
    end
    case (state_reg)
      ST_IDLE: begin
        if (have_req_reg) begin
          ta_cnt_next = ta_calc;
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        if (ta_cnt_reg != 3'h0) begin
          if (tick) begin
            ta_cnt_next = ta_cnt_reg - 3'h1;
          end
        end else if (!cur_async) begin
          state_next = ST_BURST;
          prev_valid_next = 1'b1;
          prev_async_next = 1'b0;
          prev_wr_next = cur_wr_reg;
          prev_cs_next = cur_cs_reg;
        end else if (tick && (!cur_wr_reg || buf_valid)) begin
          enter = 1'b1;
          prev_valid_next = 1'b1;
          prev_async_next = 1'b1;
          prev_wr_next = cur_wr_reg;
          prev_cs_next = cur_cs_reg;
        end
      end
      ST_BURST, ST_DESEL: begin
        if (tick) begin
          if (state_reg == ST_BURST || cont) begin
            // a write with no data yet waits with the bus idle
            issue = !cur_wr_reg || buf_valid;
            state_next = ST_BURST;
          end else begin
            ads_next = read_enable_select[prev_cs_reg];
            state_next = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (rd_pipe_reg == 4'h0 && wv_pipe_reg == 4'h0 && sync_output_enable_pin) begin
          state_next = ST_IDLE;
        end
      end
      ST_ASTB: begin
        if (tick) begin
          async_drive = 1'b1;
          cs_n_next[cur_cs_reg] = 1'b0;
          be_n_next = byte_enable_n;
          doe_next = cur_wr_reg;
          if (wait_now && ext_cnt_reg != wait_extension_limit) begin
            astb_next = 1'b0;
            ext_cnt_next = ext_cnt_reg + 8'h01;
          end else begin
            timeout = wait_now;
            state_next = ST_AHOLD;
            if (!cur_wr_reg) begin
              rd_valid_next = 1'b1;
              rd_data_next = data_s;
            end
            cur_addr_next = ssp_step(cur_addr_reg, cur_w);
            if (beats_reg == 4'h0) begin
              have_req_next = 1'b0;
            end else begin
              beats_next = beats_reg - 4'h1;
            end
          end
        end
      end
      ST_AHOLD: begin
        if (tick) begin
          if (have_req_reg && (!cur_wr_reg || buf_valid)) begin
            enter = 1'b1;
          end else if (have_req_reg) begin
            async_drive = 1'b1;
            cs_n_next[cur_cs_reg] = 1'b0;
            be_n_next = byte_enable_n;
            doe_next = cur_wr_reg;
          end else begin
            state_next = ST_DRAIN;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // one command per link cycle, each with its own address
    if (issue) begin
      if (cur_wr_reg || !cur_ext) begin
        cs_n_next[cur_cs_reg] = 1'b0;
      end
      ea_next = ssp_ea(cur_addr_reg, cur_w);
      ba_next = ssp_ba(cur_addr_reg, cur_w);
      ads_next = cur_sre ? cur_wr_reg : 1'b0;
      if (cur_wr_reg) begin
        swe_next = 1'b0;
        pop = 1'b1;
        wv_pipe_next[0] = 1'b1;
        be_n_next = ~(buf_data[71:64] & lanes);
      end else begin
        rd_pipe_next[0] = 1'b1;
        be_n_next = cur_rbe ? ~lanes : 8'hff;
      end
      cur_addr_next = ssp_step(cur_addr_reg, cur_w);
      if (beats_reg == 4'h0) begin
        have_req_next = 1'b0;
        state_next = ST_DESEL;
      end else begin
        beats_next = beats_reg - 4'h1;
      end
    end
    if (enter) begin
      async_drive = 1'b1;
      state_next = ST_ASTB;
      ext_cnt_next = 8'h00;
      cs_n_next[cur_cs_reg] = 1'b0;
      astb_next = 1'b0;
      ea_next = ssp_ea(cur_addr_reg, cur_w);
      ba_next = ssp_ba(cur_addr_reg, cur_w);
      doe_next = cur_wr_reg;
      if (cur_wr_reg) begin
        pop = 1'b1;
        dout_next = buf_data[63:0];
        be_n_next = ~(buf_data[71:64] & lanes);
      end else begin
        be_n_next = ~lanes;
      end
    end
    if (tick) begin
      // enable covers the cycle before data and the data cycle itself
      soe_on = rd_pipe_next[rl_p] | rd_pipe_next[rl_p - 2'b01];
      soe_next = ~soe_on;
      if (soe_on && chip_select_extend[prev_cs_reg]) begin
        cs_n_next[prev_cs_reg] = 1'b0;
      end
      if (!async_drive) begin
        doe_next = wv_pipe_next[wl_p];
        dout_next = wd_pipe_next[wl_p * `SSP_BUF_W +: `SSP_DW];
      end
    end
  end

  always @* begin
    irq_en_next = irq_enable_set_reg;
    if (irq_enable_clear_wr && timeout_irq_enable_clear) begin
      irq_en_next = 1'b0;
    end
    if (irq_enable_set_wr && timeout_irq_enable_set) begin
      irq_en_next = 1'b1;
    end
    raw_next = irq_unmasked_reg;
    gated_next = irq_gated_reg;
    // either flag written with 1 clears both; a fresh time-out wins over the clear
    if ((irq_unmasked_wr && timeout_raw_flag) || (irq_gated_wr && timeout_gated_flag)) begin
      raw_next = 1'b0;
      gated_next = 1'b0;
    end
    if (timeout) begin
      raw_next = 1'b1;
      if (irq_enable_set_reg) begin
        gated_next = 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (clr) begin
      irq_enable_set_reg <= `SSP_IRQ_EN_RST;
      irq_enable_clear_reg <= `SSP_IRQ_EN_RST;
      irq_unmasked_reg <= 1'b0;
      irq_gated_reg <= 1'b0;
      timeout_irq <= 1'b0;
    end else begin
      irq_enable_set_reg <= irq_en_next;
      irq_enable_clear_reg <= irq_en_next;
      irq_unmasked_reg <= raw_next;
      irq_gated_reg <= gated_next;
      timeout_irq <= gated_next;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      link_d_reg <= 1'b0;
      memory_clock_out <= 1'b0;
    end else begin
      link_d_reg <= link_s;
      memory_clock_out <= link_s;
    end
  end

  always @(posedge ref_clk) begin
    if (clr) begin
      state_reg <= ST_IDLE;
      have_req_reg <= 1'b0;
      cur_wr_reg <= 1'b0;
      cur_cs_reg <= 2'h0;
      cur_addr_reg <= 23'h000000;
      beats_reg <= 4'h0;
      prev_valid_reg <= 1'b0;
      prev_async_reg <= 1'b0;
      prev_wr_reg <= 1'b0;
      prev_cs_reg <= 2'h0;
      ta_cnt_reg <= 3'h0;
      ext_cnt_reg <= 8'h00;
      rd_pipe_reg <= 4'h0;
      wv_pipe_reg <= 4'h0;
      wd_pipe_reg <= 288'h0;
      req_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 64'h0;
      chip_select_n <= 4'hf;
      ext_address_out <= 20'h00000;
      bank_out <= 2'h0;
      byte_enable_n <= 8'hff;
      ext_data_out <= 64'h0;
      ext_data_oe <= 1'b0;
      addr_strobe_or_read_en <= 1'b1;
      sync_output_enable_pin <= 1'b1;
      sync_write_enable_pin <= 1'b1;
      async_strobe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
      have_req_reg <= have_req_next;
      cur_wr_reg <= cur_wr_next;
      cur_cs_reg <= cur_cs_next;
      cur_addr_reg <= cur_addr_next;
      beats_reg <= beats_next;
      prev_valid_reg <= prev_valid_next;
      prev_async_reg <= prev_async_next;
      prev_wr_reg <= prev_wr_next;
      prev_cs_reg <= prev_cs_next;
      ta_cnt_reg <= ta_cnt_next;
      ext_cnt_reg <= ext_cnt_next;
      rd_pipe_reg <= rd_pipe_next;
      wv_pipe_reg <= wv_pipe_next;
      wd_pipe_reg <= wd_pipe_next;
      // a request is only accepted while idle or while a deselect is pending
      req_ready <= ~have_req_next & ((state_next == ST_IDLE) | (state_next == ST_DESEL));
      rd_valid <= rd_valid_next;
      rd_data <= rd_data_next;
      chip_select_n <= cs_n_next;
      ext_address_out <= ea_next;
      bank_out <= ba_next;
      byte_enable_n <= be_n_next;
      ext_data_out <= dout_next;
      ext_data_oe <= doe_next;
      addr_strobe_or_read_en <= ads_next;
      sync_output_enable_pin <= soe_next;
      sync_write_enable_pin <= swe_next;
      async_strobe_n <= astb_next;
    end
  end
endmodule // ssp_top

// >>> tb/ssp_top_properties.sv
// interrupt flag checks on the sram port
// bound onto ssp_top; one reference clock domain
module ssp_top_properties (
  input wire ref_clk,
  input wire rst,
  input wire soft_rst,
  input wire irq_enable_set_wr,
  input wire timeout_irq_enable_set,
  input wire irq_enable_clear_wr,
  input wire timeout_irq_enable_clear,
  input wire irq_unmasked_wr,
  input wire timeout_raw_flag,
  input wire irq_gated_wr,
  input wire timeout_gated_flag,
  input wire irq_enable_set_reg,
  input wire irq_enable_clear_reg,
  input wire irq_unmasked_reg,
  input wire irq_gated_reg,
  input wire timeout_irq,
  input wire async_strobe_n
);
  wire en_w = irq_enable_set_wr & timeout_irq_enable_set;
  wire dis_w = irq_enable_clear_wr & timeout_irq_enable_clear;
  wire clr_w = (irq_unmasked_wr & timeout_raw_flag) | (irq_gated_wr & timeout_gated_flag);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || soft_rst);
  irq_level_a: assert property (timeout_irq == irq_gated_reg) else $error("irq out off");
  en_mirror_a: assert property (irq_enable_set_reg == irq_enable_clear_reg) else $error("mirror off");
  en_set_a: assert property (en_w |=> irq_enable_set_reg) else $error("set lost");
  en_clear_a: assert property (dis_w && !en_w |=> !irq_enable_set_reg) else $error("clear lost");
  gated_en_a: assert property ($rose(irq_gated_reg) |-> $past(irq_enable_set_reg)) else $error("gated off");
  raw_hold_a: assert property (irq_unmasked_reg && !clr_w |=> irq_unmasked_reg) else $error("raw lost");
  // only judged while idle, since a time-out outranks a clear
  flag_clear_a: assert property (clr_w && async_strobe_n && $past(async_strobe_n) |=>
    !irq_unmasked_reg && !irq_gated_reg) else $error("flags kept");
  soft_clear_a: assert property (disable iff (rst) soft_rst |=> !irq_unmasked_reg && !irq_enable_set_reg)
    else $error("soft reset kept");
  cover property (timeout_irq);
  cover property ($fell(irq_unmasked_reg));
  cover property (irq_unmasked_reg && !irq_gated_reg);
endmodule // ssp_top_properties
bind ssp_top ssp_top_properties chk_u (.*);

// >>> tb/ssp_mem_model.sv
// behavioural sync sram: read latency 2, write latency 0, 64-bit words
// assumes pins settle between edges of link_clk
module ssp_mem_model (
  input wire link_clk,
  input wire hang,
  input wire [3:0] chip_select_n,
  input wire [19:0] ext_address_out,
  input wire [63:0] ext_data_out,
  input wire addr_strobe_or_read_en,
  input wire sync_output_enable_pin,
  input wire sync_write_enable_pin,
  input wire async_strobe_n,
  output wire [63:0] ext_data_in,
  output wire async_ready_in
);
  logic [63:0] mem [16];
  logic [63:0] q1, q2, q3;
  logic oe_d;
  wire cmd = ~&chip_select_n & ~addr_strobe_or_read_en;
  always @(posedge link_clk) begin
    if (cmd & ~sync_write_enable_pin) mem[ext_address_out[3:0]] <= ext_data_out;
    q1 <= mem[ext_address_out[3:0]];
    q2 <= q1;
    q3 <= q2;
    oe_d <= sync_output_enable_pin;
  end
  // released bus shows the inverse so a stale sample cannot pass
  assign ext_data_in = (sync_output_enable_pin & oe_d) ? ~q3 : q3;
  assign async_ready_in = hang & ~async_strobe_n;
endmodule // ssp_mem_model

// >>> tb/ssp_top_tb.sv
// self-checking bench: sync sram port, write buffer, time-out interrupt
// assumes ssp_top, the memory model and the bound checker
module ssp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'h0, link_clk = 1'h0, rst = 1'h1, soft_rst = 1'h0, hang = 1'h0;
  logic req_valid = 1'h0, req_write = 1'h0, wr_valid = 1'h0;
  logic [1:0] req_cs = 2'h0, turnaround_count = 2'h0, bank_out;
  logic [3:0] req_len = 4'h0, sync_select = 4'h1, chip_select_extend = 4'h0;
  logic [3:0] read_byte_enable_drive = 4'h0, read_enable_select = 4'h0, chip_select_n;
  logic [7:0] irq_w = 8'h00, wait_extension_limit = 8'h03, wr_be = 8'hff, byte_enable_n;
  logic [63:0] wr_data = 64'h0, rd_data, ext_data_in, ext_data_out;
  logic [19:0] ext_address_out;
  logic req_ready, wr_ready, rd_valid, timeout_irq, async_ready_in, addr_strobe_or_read_en;
  logic irq_enable_set_reg, irq_enable_clear_reg, irq_unmasked_reg, irq_gated_reg;
  logic sync_output_enable_pin, sync_write_enable_pin, async_strobe_n, memory_clock_out, ext_data_oe;
  // set write, set data, clear write, clear data, expected enable
  logic [4:0] rows [6] = '{5'h10, 5'h19, 5'h05, 5'h06, 5'h1f, 5'h06};
  int checks = 0, n_mismatch = 0, cyc = 0;
  ssp_top dut_u (.ref_clk, .rst, .soft_rst, .link_clk, .async_ready_in, .ext_data_in, .req_valid, .req_ready,
    .req_write, .req_cs, .req_addr(23'h0), .req_len, .wr_valid, .wr_ready, .wr_data, .wr_be, .rd_valid, .rd_data,
    .sync_select, .read_latency_field(8'haa), .write_latency_field(8'h00), .chip_select_extend,
    .read_byte_enable_drive, .read_enable_select, .bus_width_select(8'hff), .turnaround_count,
    .wait_extension_limit, .async_ready_wait_high(1'h1), .irq_enable_set_wr(irq_w[7]),
    .timeout_irq_enable_set(irq_w[6]), .irq_enable_clear_wr(irq_w[5]), .timeout_irq_enable_clear(irq_w[4]),
    .irq_unmasked_wr(irq_w[3]), .timeout_raw_flag(irq_w[2]), .irq_gated_wr(irq_w[1]),
    .timeout_gated_flag(irq_w[0]), .irq_enable_set_reg, .irq_enable_clear_reg, .irq_unmasked_reg,
    .irq_gated_reg, .timeout_irq, .memory_clock_out, .chip_select_n, .ext_address_out, .bank_out,
    .byte_enable_n, .ext_data_out, .ext_data_oe, .addr_strobe_or_read_en, .sync_output_enable_pin,
    .sync_write_enable_pin, .async_strobe_n);
  ssp_mem_model mem_u (.link_clk, .hang, .chip_select_n, .ext_address_out, .ext_data_out, .addr_strobe_or_read_en,
    .sync_output_enable_pin, .sync_write_enable_pin, .async_strobe_n, .ext_data_in, .async_ready_in);
  always #2 ref_clk = ~ref_clk;
  // offset keeps the link edges off the reference edges
  initial begin
    #0.7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      results;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic pulse(input logic [7:0] v);
    irq_w = v;
    @(negedge ref_clk) irq_w = 8'h00;
    @(negedge ref_clk);
  endtask
  task automatic rq(input logic wr, input logic [1:0] cs, input logic [3:0] len);
    {req_write, req_cs, req_len, req_valid} = {wr, cs, len, 1'h1};
    while (req_ready !== 1'h1) @(negedge ref_clk);
    @(negedge ref_clk) req_valid = 1'h0;
  endtask
  function automatic logic [63:0] dat(int k);
    return {16{k[3:0]}} ^ 64'hc3a5_5a3c_0f0f_f0f0;
  endfunction
  task automatic rd2;
    for (int k = 0; k < 2; k++) begin
      @(negedge ref_clk iff rd_valid === 1'h1);
      chk(rd_data, dat(k));
    end
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    chk(chip_select_n, 4'hf);
    chk(req_ready, 1'h0);
    chk({memory_clock_out, bank_out, byte_enable_n, ext_data_oe}, 12'h1fe);
    rst = 1'h0;
    @(negedge ref_clk);
    chk(req_ready, 1'h1);
    foreach (rows[i]) begin
      pulse({rows[i][4:1], 4'h0});
      chk(irq_enable_set_reg, rows[i][0]);
      chk(irq_enable_clear_reg, rows[i][0]);
    end
    for (int k = 0; k < 2; k++) begin
      {wr_data, wr_valid} = {dat(k), 1'h1};
      @(negedge ref_clk);
    end
    wr_valid = 1'h0;
    chk(wr_ready, 1'h0);
    rq(1'h1, 2'h0, 4'h1);
    rq(1'h0, 2'h0, 4'h1);
    chk(wr_ready, 1'h1);
    rd2;
    // second chip select runs async timing and its ready input hangs
    {read_byte_enable_drive, chip_select_extend, turnaround_count, wr_be, read_enable_select, hang} =
      {4'h1, 4'h1, 2'h2, 8'h0f, 4'h2, 1'h1};
    pulse(8'hc0);
    rq(1'h0, 2'h1, 4'h0);
    @(negedge ref_clk iff timeout_irq === 1'h1);
    chk(irq_unmasked_reg, 1'h1);
    @(negedge ref_clk iff req_ready === 1'h1);
    pulse(8'h03);
    chk({irq_unmasked_reg, timeout_irq}, 2'h0);
    pulse(8'h30);
    wait_extension_limit = 8'h01;
    rq(1'h0, 2'h1, 4'h0);
    @(negedge ref_clk iff irq_unmasked_reg === 1'h1);
    @(negedge ref_clk iff req_ready === 1'h1);
    chk(irq_gated_reg, 1'h0);
    pulse(8'h0c);
    chk(irq_unmasked_reg, 1'h0);
    pulse(8'hc0);
    soft_rst = 1'h1;
    repeat (3) @(negedge ref_clk);
    soft_rst = 1'h0;
    chk(irq_enable_set_reg, 1'h0);
    // extended select and driven byte enables on the first chip select
    rq(1'h0, 2'h0, 4'h1);
    rd2;
    results;
  end
endmodule // ssp_top_tb
